// ===== common/cmc_defines.svh
// Constants for the configuration memory check block.
`ifndef CMC_DEFINES_SVH
`define CMC_DEFINES_SVH
`define CMC_SIG_W          16
`define CMC_POLY           16'h8005
`define CMC_REPORT_W       46
`define CMC_LOC_W          14
`define CMC_REP_SYN_LSB    0
`define CMC_REP_BIT_LSB    16
`define CMC_REP_FRAME_LSB  30
`define CMC_REP_TYPE_LSB   44
`define CMC_TYPE_NONE      2'h0
`define CMC_TYPE_SINGLE    2'h1
`define CMC_TYPE_ADJACENT  2'h2
`define CMC_TYPE_UNKNOWN   2'h3
`define CMC_INJ_SINGLE     2'h1
`define CMC_INJ_ADJACENT   2'h2
`define CMC_GAP_TICKS      6'h20
`define CMC_FRAME_BITS_DEF 64
`define CMC_NUM_FRAMES_DEF 8
`define CMC_ED_DIV_DEF     2
`define CMC_STATUS_RST     1'h1
`endif

// ===== common/cmc_pkg.sv
// Types shared by the configuration memory check block.
package cmc_pkg;
	typedef enum logic [1:0] {
		CMC_IDLE,
		CMC_SCAN,
		CMC_SEARCH
	} cmc_state_t;
endpackage : cmc_pkg

// ===== logic/cmc_crc_step.sv
// One serial step of the 16-bit check polynomial, most significant bit first.
`timescale 1ns/10ps
`default_nettype none
`include "cmc_defines.svh"
module cmc_crc_step
	import cmc_pkg::*;
(
	// Step input
	input  wire logic [15:0] i_crc,
	input  wire logic        i_bit,
	// Step result
	output logic      [15:0] o_crc
);
	assign o_crc = {i_crc[14:0], 1'h0} ^ ((i_crc[15] ^ i_bit) ? `CMC_POLY : 16'h0000);
endmodule : cmc_crc_step
`default_nettype wire

// ===== logic/cmc_report_shift.sv
// Capture-and-shift register that unloads an error report serially.
`timescale 1ns/10ps
`default_nettype none
`include "cmc_defines.svh"
module cmc_report_shift
	import cmc_pkg::*;
#(
	parameter int W = `CMC_REPORT_W
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// Reader control
	input  wire logic         i_capture,
	input  wire logic         i_shift,
	// Report in, serial out
	input  wire logic [W-1:0] i_data,
	output logic              o_sout
);
	typedef struct packed {
		logic [W-1:0] sh;
	} cmc_rs_t;
	cmc_rs_t r_reg;
	cmc_rs_t r_next;

	// Capture wins over shift so a reader never unloads half of an old report.
	always_comb begin
		r_next = r_reg;
		if (i_capture) begin
			r_next.sh = i_data;
		end else if (i_shift) begin
			r_next.sh = {1'h0, r_reg.sh[W-1:1]};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_sout = r_reg.sh[0];
endmodule : cmc_report_shift
`default_nettype wire

// ===== logic/cmc_checker.sv
// Frame-by-frame check of the configuration cell memory with error location search.
`timescale 1ns/10ps
`default_nettype none
`include "cmc_defines.svh"
module cmc_checker
	import cmc_pkg::*;
#(
	parameter int FRAME_BITS = `CMC_FRAME_BITS_DEF,
	parameter int NUM_FRAMES = `CMC_NUM_FRAMES_DEF,
	parameter int ED_DIV     = `CMC_ED_DIV_DEF,
	localparam int TOT = FRAME_BITS + `CMC_SIG_W,
	localparam int BW  = $clog2(TOT),
	localparam int FW  = (NUM_FRAMES > 1) ? $clog2(NUM_FRAMES) : 1
) (
	// Clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	// Mode
	input  wire logic                   i_ed_enable,
	input  wire logic                   i_user_mode,
	// Config cell memory readback
	output logic [FW-1:0]               o_rd_frame,
	output logic [BW-1:0]               o_rd_bit,
	input  wire logic                   i_rd_data,
	// Configuration loading
	input  wire logic                   i_load_valid,
	input  wire logic                   i_load_bit,
	output logic                        o_config_status_n,
	// Error flag pin and its user I/O side
	input  wire logic                   i_flag_pin_in,
	output logic                        o_flag_pin_out,
	output logic                        o_flag_pin_oe,
	input  wire logic                   i_user_pin_out,
	input  wire logic                   i_user_pin_oe,
	output logic                        o_user_pin_in,
	output logic                        o_error_flag,
	// Signature registers and test access
	output logic [`CMC_SIG_W-1:0]       o_frame_signature,
	output logic [`CMC_SIG_W-1:0]       o_first_signature,
	input  wire logic                   i_sig_wr,
	input  wire logic [FW-1:0]          i_sig_frame,
	input  wire logic [`CMC_SIG_W-1:0]  i_sig_data,
	// Fault injection
	input  wire logic                   i_inject_wr,
	input  wire logic [1:0]             i_inject_type,
	input  wire logic [`CMC_LOC_W-1:0]  i_inject_loc,
	// Error report readout
	input  wire logic                   i_report_shift_instruction,
	input  wire logic                   i_jtag_capture,
	input  wire logic                   i_jtag_shift,
	output logic                        o_jtag_sout,
	input  wire logic                   i_core_capture,
	input  wire logic                   i_core_shift,
	output logic                        o_core_sout
);
	typedef struct packed {
		logic [7:0]                               div;
		cmc_state_t                               st;
		logic [FW-1:0]                            frame;
		logic [BW-1:0]                            bitn;
		logic [15:0]                              crc;
		logic [15:0]                              syn;
		logic [15:0]                              t;
		logic [15:0]                              first_sig;
		logic [NUM_FRAMES-1:0][`CMC_SIG_W-1:0]    store;
		logic [`CMC_REPORT_W-1:0]                 report;
		logic                                     pend;
		logic                                     flag;
		logic [5:0]                               gap;
		logic [1:0]                               inj_type_p;
		logic [`CMC_LOC_W-1:0]                    inj_loc_p;
		logic [1:0]                               inj_type;
		logic [`CMC_LOC_W-1:0]                    inj_loc;
		logic [FW-1:0]                            lframe;
		logic [BW-1:0]                            lbit;
		logic [15:0]                              lcrc;
		logic                                     status_n;
		logic                                     pin_out;
		logic                                     pin_oe;
		logic                                     user_in;
	} cmc_st_t;

	cmc_st_t     r_reg;
	cmc_st_t     r_next;
	logic        tick;
	logic        scan_bit;
	logic        inj_hit;
	logic        last_bit;
	logic [15:0] scan_crc;
	logic [15:0] load_crc;
	logic [15:0] t_step;
	logic [15:0] adj_syn;

	// =====================================================================
	// Check polynomial steps
	// =====================================================================
	cmc_crc_step u_scan_step (.i_crc(r_reg.crc),  .i_bit(scan_bit),   .o_crc(scan_crc));
	cmc_crc_step u_load_step (.i_crc(r_reg.lcrc), .i_bit(i_load_bit), .o_crc(load_crc));
	cmc_crc_step u_srch_step (.i_crc(r_reg.t),    .i_bit(1'h0),       .o_crc(t_step));

	// The error-detection clock is a divided enable so the scan rate can be slowed.
	assign tick     = (r_reg.div == 8'(ED_DIV - 1));
	assign last_bit = (r_reg.bitn == BW'(TOT - 1));
	assign adj_syn  = t_step ^ r_reg.t;
	assign inj_hit  = (r_reg.frame == '0) && (
		((r_reg.inj_type == `CMC_INJ_SINGLE || r_reg.inj_type == `CMC_INJ_ADJACENT)
			&& (r_reg.bitn == BW'(r_reg.inj_loc)))
		|| ((r_reg.inj_type == `CMC_INJ_ADJACENT)
			&& (r_reg.bitn == BW'(r_reg.inj_loc + 14'h0001))));

	always_comb begin
		int sidx;
		sidx = `CMC_SIG_W - 1 - (int'(r_reg.bitn) - FRAME_BITS);
		if (r_reg.bitn < BW'(FRAME_BITS)) begin
			scan_bit = i_rd_data ^ inj_hit;
		end else begin
			scan_bit = r_reg.store[r_reg.frame][sidx[3:0]];
		end
	end

	// =====================================================================
	// Next state
	// =====================================================================
	always_comb begin
		int       loc;
		logic     adv;
		logic     fall;
		logic [1:0] ty;
		loc    = 0;
		adv    = 1'h0;
		fall   = 1'h0;
		ty     = `CMC_TYPE_UNKNOWN;
		r_next = r_reg;
		r_next.div = tick ? 8'h00 : r_reg.div + 8'h01;

		if (i_inject_wr) begin
			r_next.inj_type_p = i_inject_type;
			r_next.inj_loc_p  = i_inject_loc;
		end

		// Scan and search engine, advancing only on the error-detection tick.
		if (!(i_ed_enable && i_user_mode)) begin
			r_next.st   = CMC_IDLE;
			r_next.flag = 1'h0;
			r_next.pend = 1'h0;
		end else if (tick) begin
			if (r_reg.gap != 6'h00) begin
				r_next.gap = r_reg.gap - 6'h01;
			end
			case (r_reg.st)
				CMC_IDLE: begin
					r_next.st          = CMC_SCAN;
					r_next.frame       = '0;
					r_next.bitn        = '0;
					r_next.crc         = 16'h0000;
					r_next.inj_type    = r_next.inj_type_p;
					r_next.inj_loc     = r_next.inj_loc_p;
				end
				CMC_SCAN: begin
					r_next.crc  = scan_crc;
					r_next.bitn = r_reg.bitn + BW'(1);
					if (last_bit) begin
						r_next.syn = scan_crc;
						fall       = 1'h1;
						if (r_reg.frame == '0) begin
							r_next.first_sig = scan_crc;
						end
						if (scan_crc == 16'h0000) begin
							adv = 1'h1;
						end else begin
							r_next.st   = CMC_SEARCH;
							r_next.bitn = '0;
							r_next.t    = `CMC_POLY;
						end
					end
				end
				CMC_SEARCH: begin
					// Trial syndromes walk back from the last bit of the frame.
					r_next.t    = t_step;
					r_next.bitn = r_reg.bitn + BW'(1);
					if (r_reg.t == r_reg.syn) begin
						ty  = `CMC_TYPE_SINGLE;
						loc = TOT - 1 - int'(r_reg.bitn);
					end else if (adj_syn == r_reg.syn && !last_bit) begin
						ty  = `CMC_TYPE_ADJACENT;
						loc = TOT - 2 - int'(r_reg.bitn);
					end
					if (ty != `CMC_TYPE_UNKNOWN || last_bit) begin
						r_next.report = {ty, (ty == `CMC_TYPE_UNKNOWN) ? 14'h0000
							: `CMC_LOC_W'(r_reg.frame), `CMC_LOC_W'(loc), r_reg.syn};
						r_next.pend   = 1'h1;
						adv           = 1'h1;
					end
				end
				default: begin
					r_next.st = CMC_IDLE;
				end
			endcase
			if (adv) begin
				r_next.st    = CMC_SCAN;
				r_next.bitn  = '0;
				r_next.crc   = 16'h0000;
				r_next.frame = (r_reg.frame == FW'(NUM_FRAMES - 1)) ? '0 : r_reg.frame + FW'(1);
				if (r_next.frame == '0) begin
					r_next.inj_type = r_next.inj_type_p;
					r_next.inj_loc  = r_next.inj_loc_p;
				end
			end
			if (fall && r_reg.flag) begin
				r_next.flag = 1'h0;
				r_next.gap  = `CMC_GAP_TICKS;
			end else if (r_reg.pend && !r_reg.flag && r_reg.gap == 6'h00
					&& r_reg.syn != 16'h0000) begin
				r_next.flag = 1'h1;
				r_next.pend = 1'h0;
			end
		end

		// Loading checks each frame and keeps its check bits.
		if (!i_user_mode && i_load_valid) begin
			r_next.lcrc = load_crc;
			r_next.lbit = r_reg.lbit + BW'(1);
			if (r_reg.lbit >= BW'(FRAME_BITS)) begin
				r_next.store[r_reg.lframe] = {r_reg.store[r_reg.lframe][14:0], i_load_bit};
			end
			if (r_reg.lbit == BW'(TOT - 1)) begin
				if (load_crc != 16'h0000) begin
					r_next.status_n = 1'h0;
				end
				r_next.lbit   = '0;
				r_next.lcrc   = 16'h0000;
				r_next.lframe = (r_reg.lframe == FW'(NUM_FRAMES - 1)) ? '0
					: r_reg.lframe + FW'(1);
			end
		end
		if (i_sig_wr) begin
			r_next.store[i_sig_frame] = i_sig_data;
		end

		// Open-drain flag: release for high, drive low otherwise.
		if (i_ed_enable) begin
			r_next.pin_out = 1'h0;
			r_next.pin_oe  = !r_next.flag;
		end else begin
			r_next.pin_out = i_user_pin_out;
			r_next.pin_oe  = i_user_pin_oe;
		end
		r_next.user_in = i_flag_pin_in;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r_reg          <= '0;
			r_reg.st       <= CMC_IDLE;
			r_reg.status_n <= `CMC_STATUS_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// =====================================================================
	// Report readout
	// =====================================================================
	cmc_report_shift #(.W(`CMC_REPORT_W)) u_jtag_rs (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_capture (i_jtag_capture & i_report_shift_instruction),
		.i_shift   (i_jtag_shift & i_report_shift_instruction),
		.i_data    (r_reg.report),
		.o_sout    (o_jtag_sout)
	);
	cmc_report_shift #(.W(`CMC_REPORT_W)) u_core_rs (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_capture (i_core_capture),
		.i_shift   (i_core_shift),
		.i_data    (r_reg.report),
		.o_sout    (o_core_sout)
	);

	assign o_rd_frame        = r_reg.frame;
	assign o_rd_bit          = r_reg.bitn;
	assign o_config_status_n = r_reg.status_n;
	assign o_flag_pin_out    = r_reg.pin_out;
	assign o_flag_pin_oe     = r_reg.pin_oe;
	assign o_user_pin_in     = r_reg.user_in;
	assign o_error_flag      = r_reg.flag;
	assign o_frame_signature = r_reg.syn;
	assign o_first_signature = r_reg.first_sig;

	// =====================================================================
	// Checks
	// =====================================================================
	a_flag_has_syn: assert property (@(posedge i_clk) disable iff (i_rst)
		r_reg.flag |-> r_reg.syn != 16'h0000) else $error("flag high with zero syndrome");
	a_zero_no_flag: assert property (@(posedge i_clk) disable iff (i_rst)
		(tick && r_reg.st == CMC_SCAN && last_bit && scan_crc == 16'h0000 && i_ed_enable
			&& i_user_mode) |=> !r_reg.flag && r_reg.syn == 16'h0000)
		else $error("zero signature raised flag");
	a_fall_gap_set: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(r_reg.flag) && i_ed_enable && i_user_mode |-> r_reg.gap == 6'h20)
		else $error("low gap not started");
	a_rise_after_gap: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(r_reg.flag) |-> $past(r_reg.gap) == 6'h00) else $error("flag rose inside gap");
	a_search_starts: assert property (@(posedge i_clk) disable iff (i_rst)
		(tick && r_reg.st == CMC_SCAN && last_bit && scan_crc != 16'h0000 && i_ed_enable
			&& i_user_mode) |=> r_reg.st == CMC_SEARCH && r_reg.t == 16'h8005)
		else $error("search did not start");
	a_report_syn: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(r_reg.pend) |-> r_reg.report[15:0] == r_reg.syn) else $error("report syndrome");
	a_loc_invalid: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(r_reg.pend) && r_reg.report[45:44] == 2'h3 |-> r_reg.report[43:16] == '0)
		else $error("location given for unknown error");
	a_load_status: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_user_mode && i_load_valid && r_reg.lbit == BW'(TOT - 1) && load_crc != 16'h0000)
		|=> !o_config_status_n) else $error("status not pulled low");
	a_pin_user: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_ed_enable |=> o_flag_pin_oe == $past(i_user_pin_oe)
			&& o_flag_pin_out == $past(i_user_pin_out)) else $error("pin not released");
	a_pin_od: assert property (@(posedge i_clk) disable iff (i_rst)
		$past(i_ed_enable) && !$past(i_rst) |-> !o_flag_pin_out && o_flag_pin_oe == !$past(r_next.flag))
		else $error("flag pin not open drain");
	a_keeps_running: assert property (@(posedge i_clk) disable iff (i_rst)
		(r_reg.st == CMC_SEARCH && i_ed_enable && i_user_mode)
			|-> ##[1:1000] (r_reg.st != CMC_SEARCH)) else $error("search stalled");
endmodule : cmc_checker
`default_nettype wire

// ===== test/cmc_mem_model.sv
// Partner model: combinational cell memory and the pulled-up error flag wire.
`timescale 1ns/10ps
`default_nettype none
module cmc_mem_model #(
	parameter int FB = 64,
	parameter int NF = 4,
	localparam int TT = FB + 16
) (
	// Readback of the cell memory
	input  wire logic [$clog2(NF)-1:0] i_frame,
	input  wire logic [$clog2(TT)-1:0] i_bit,
	output logic                       o_data,
	// Flag pin drivers and the wire level
	input  wire logic                  i_pin_out,
	input  wire logic                  i_pin_oe,
	output logic                       o_pin
);
	// Data bits then check bits of each frame, filled by the bench.
	logic mem [NF][TT];
	// Steps past the frame read as zero; the scan and search phases stop at the last check bit.
	assign o_data = (int'(i_bit) < TT) ? mem[i_frame][i_bit] : 1'h0;
	// The receiver's resistor holds the wire high whenever nobody drives it.
	assign o_pin = i_pin_oe ? i_pin_out : 1'h1;
endmodule : cmc_mem_model
`default_nettype wire

// ===== test/tb_config_memory_crc_checker.sv
// Self-checking bench for the configuration memory check block.
`timescale 1ns/10ps
`default_nettype none
`include "cmc_defines.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_config_memory_crc_checker;
	localparam int FB = 64;
	localparam int NF = 4;
	localparam int TT = FB + 16;
	logic        clk, rst, en, um, rdd, lv, lb, stn, pin, po, poe, upo, upoe, upi, flg;
	logic        sw, iw, ins, jc, js, jo, cc, cs, co, fq;
	logic [1:0]  rf, sf, it;
	logic [6:0]  rb;
	logic [13:0] il;
	logic [15:0] fsig, first, sd;
	int          fail_count, n_checks, en_n, lo, seen;

	cmc_checker #(.FRAME_BITS(FB), .NUM_FRAMES(NF), .ED_DIV(1)) cmc_checker_i (
		.i_clk(clk), .i_rst(rst), .i_ed_enable(en), .i_user_mode(um),
		.o_rd_frame(rf), .o_rd_bit(rb), .i_rd_data(rdd),
		.i_load_valid(lv), .i_load_bit(lb), .o_config_status_n(stn),
		.i_flag_pin_in(pin), .o_flag_pin_out(po), .o_flag_pin_oe(poe),
		.i_user_pin_out(upo), .i_user_pin_oe(upoe), .o_user_pin_in(upi),
		.o_error_flag(flg), .o_frame_signature(fsig), .o_first_signature(first),
		.i_sig_wr(sw), .i_sig_frame(sf), .i_sig_data(sd),
		.i_inject_wr(iw), .i_inject_type(it), .i_inject_loc(il),
		.i_report_shift_instruction(ins), .i_jtag_capture(jc), .i_jtag_shift(js),
		.o_jtag_sout(jo), .i_core_capture(cc), .i_core_shift(cs), .o_core_sout(co)
	);
	cmc_mem_model #(.FB(FB), .NF(NF)) cmc_mem_model_i (
		.i_frame(rf), .i_bit(rb), .o_data(rdd),
		.i_pin_out(po), .i_pin_oe(poe), .o_pin(pin)
	);

	// ==========================================================
	// Clock, watchdog and helpers
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		tally_and_finish;
	end
	task automatic tally_and_finish;
		if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	// Bits p1 and p2 and the check bits masked by cx are flipped on the fly.
	function automatic logic [15:0] crc(input int f, n, p1, p2, input logic [15:0] cx);
		logic [15:0] c;
		logic        b;
		c = 16'h0000;
		for (int i = 0; i < n; i++) begin
			b = cmc_mem_model_i.mem[f][i] ^ (i == p1) ^ (i == p2) ^ (i >= FB ? cx[TT-1-i] : 1'h0);
			c = {c[14:0], 1'h0} ^ ((c[15] ^ b) ? `CMC_POLY : 16'h0000);
		end
		return c;
	endfunction : crc

	task automatic wait_flag(input logic v);
		for (int k = 0; k < 3000 && flg !== v; k++) @(negedge clk);
	endtask : wait_flag

	task automatic read_rep(input int jt, output logic [45:0] r);
		ins = 1'(jt);
		jc = 1'(jt);
		cc = !jt;
		@(negedge clk);
		jc = 1'h0;
		cc = 1'h0;
		for (int i = 0; i < 46; i++) begin
			r[i] = jt ? jo : co;
			js = 1'(jt);
			cs = !jt;
			@(negedge clk);
		end
		js = 1'h0;
		cs = 1'h0;
		ins = 1'h0;
	endtask : read_rep

	task automatic inject(input logic [1:0] t, input int p);
		it = t;
		il = 14'(p);
		iw = 1'h1;
		@(negedge clk);
		iw = 1'h0;
	endtask : inject

	// Modes: 0 single, 1 adjacent, 2 three apart, 3 injected single, 4 injected adjacent.
	task automatic err(input int f, p, m, jt);
		logic [45:0] r;
		logic [15:0] s;
		logic [6:0]  b0;
		int          p2;
		p2 = (m == 1 || m == 4) ? p + 1 : (m == 2) ? p + 3 : -1;
		s = crc(f, TT, p, p2, 16'h0000);
		if (m >= 3) inject(m == 3 ? `CMC_INJ_SINGLE : `CMC_INJ_ADJACENT, p);
		else begin
			// Flipping mid-frame would split an adjacent pair across two passes.
			while (rf === 2'(f)) @(negedge clk);
			cmc_mem_model_i.mem[f][p] ^= 1'h1;
			if (p2 >= 0) cmc_mem_model_i.mem[f][p2] ^= 1'h1;
		end
		wait_flag(1'h1);
		`CHK(flg, 1'h1)
		`CHK(fsig, s)
		if (m >= 3) `CHK(first, s)
		b0 = rb;
		read_rep(jt, r);
		`CHK(rb !== b0, 1'h1)
		if (m >= 3) inject(2'h0, 0);
		else begin
			cmc_mem_model_i.mem[f][p] ^= 1'h1;
			if (p2 >= 0) cmc_mem_model_i.mem[f][p2] ^= 1'h1;
		end
		`CHK(r[15:0], s)
		`CHK(r[45:44], (m == 0 || m == 3) ? `CMC_TYPE_SINGLE : (m == 2) ? `CMC_TYPE_UNKNOWN : `CMC_TYPE_ADJACENT)
		`CHK(r[43:30], (m == 2) ? 14'h0000 : 14'(f))
		`CHK(r[29:16], (m == 2) ? 14'h0000 : 14'(p))
		wait_flag(1'h0);
	endtask : err

	task automatic load(input int bad);
		for (int f = 0; f < NF; f++)
			for (int i = 0; i < TT; i++) begin
				lv = 1'h1;
				lb = cmc_mem_model_i.mem[f][i] ^ (f == bad && i == TT - 1);
				@(negedge clk);
			end
		lv = 1'h0;
		repeat (2) @(negedge clk);
	endtask : load

	// ==========================================================
	// Flag wire level and the low gap between two raised flags
	always @(negedge clk) begin
		if (en_n >= 2 && en && !rst) `CHK(pin, flg)
		en_n = (rst || !en) ? 0 : en_n + 1;
		if (fq && !flg) begin
			lo = 0;
			seen = 1;
		end else if (!flg) lo++;
		if (!fq && flg && seen) `CHK(lo + 1 >= 32, 1'h1)
		fq = flg;
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [15:0] c;
		int          f;
		logic [45:0] r;
		{rst, en, um, lv, lb, upo, upoe, sw, iw, ins, jc, js, cc, cs, fq} = '1;
		{en, um, lv, lb, upo, upoe, sw, iw, ins, jc, js, cc, cs, fq} = '0;
		{sf, it, il, sd} = '0;
		{fail_count, n_checks, en_n, lo, seen} = '0;
		void'($urandom(32'hA48C64AB));
		for (int g = 0; g < NF; g++) begin
			for (int i = 0; i < TT; i++) cmc_mem_model_i.mem[g][i] = (i < FB) ? 1'($urandom) : 1'h0;
			c = crc(g, FB, -1, -1, 16'h0000);
			for (int j = 0; j < 16; j++) cmc_mem_model_i.mem[g][FB + j] = c[15 - j];
		end
		repeat (2) @(negedge clk);
		rst = 1'h0;
		`CHK(stn, 1'h1)
		`CHK(flg, 1'h0)
		upoe = 1'h1;
		upo = 1'($urandom);
		repeat (3) @(negedge clk);
		`CHK(pin, upo)
		`CHK(upi, upo)
		upoe = 1'h0;
		load(-1);
		`CHK(stn, 1'h1)
		um = 1'h1;
		en = 1'h1;
		repeat (NF * TT + 20) @(negedge clk);
		`CHK(flg, 1'h0)
		`CHK(fsig, 16'h0000)
		err(2, 0, 0, 0);
		err(1, FB - 2, 1, 1);
		err(3, 10, 2, 0);
		err(0, 5, 3, 1);
		err(0, FB - 2, 4, 0);
		repeat (6) err($urandom_range(NF - 1), $urandom_range(FB - 5), $urandom_range(2), $urandom_range(1));
		// Two corrupted frames left unread: the later report replaces the earlier one.
		while (rf === 2'h1 || rf === 2'h2) @(negedge clk);
		cmc_mem_model_i.mem[1][3] ^= 1'h1;
		cmc_mem_model_i.mem[2][7] ^= 1'h1;
		wait_flag(1'h1);
		wait_flag(1'h0);
		wait_flag(1'h1);
		read_rep(0, r);
		`CHK(r[43:16], {14'h0002, 14'h0007})
		cmc_mem_model_i.mem[1][3] ^= 1'h1;
		cmc_mem_model_i.mem[2][7] ^= 1'h1;
		wait_flag(1'h0);
		f = $urandom_range(NF - 1);
		c = crc(f, FB, -1, -1, 16'h0000);
		{sf, sd, sw} = {2'(f), c ^ 16'h0100, 1'h1};
		@(negedge clk);
		sw = 1'h0;
		wait_flag(1'h1);
		`CHK(fsig, crc(f, TT, -1, -1, 16'h0100))
		{sd, sw} = {c, 1'h1};
		@(negedge clk);
		sw = 1'h0;
		wait_flag(1'h0);
		{rst, en, um} = 3'h4;
		repeat (2) @(negedge clk);
		rst = 1'h0;
		load(2);
		`CHK(stn, 1'h0)
		rst = 1'h1;
		repeat (2) @(negedge clk);
		rst = 1'h0;
		`CHK(stn, 1'h1)
		tally_and_finish;
	end
endmodule : tb_config_memory_crc_checker
`default_nettype wire
